/* inc/scss_pkg.sv */
// types for clock source select
`include "scss_regs.svh"
package scss_pkg;
    typedef struct packed {
        logic [`SCSS_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scss_bus_req_t;
    typedef struct packed {
        logic stop_req;
        logic wait_req;
        logic self_clock;
        logic special_mode;
    } scss_mode_t;
    typedef struct packed {
        logic use_pll;
        logic osc_enable;
        logic pll_power;
        logic rti_run;
        logic rti_init;
        logic cop_run;
        logic cop_init;
    } scss_ctl_t;
    typedef enum logic [1:0] {
        SCSS_RUN = 2'b00,
        SCSS_WAIT = 2'b01,
        SCSS_STOP = 2'b10
    } scss_lp_t;
endpackage

/* inc/scss_regs.svh */
// register offsets, field positions, reset values and timing for clock source select
`ifndef SCSS_REGS_SVH
`define SCSS_REGS_SVH
`define SCSS_ADDR_W 4
`define SCSS_OFF_CLKSRC 4'h5
`define SCSS_OFF_PLL_CONTROL 4'h6
`define SCSS_SEL_BIT 7
`define SCSS_STOPRUN_BIT 6
`define SCSS_CFG_BIT 5
`define SCSS_PLL_HALT_IN_WAIT_BIT 3
`define SCSS_PERIODIC_TIMER_HALT_IN_WAIT_BIT 1
`define SCSS_WATCHDOG_HALT_IN_WAIT_BIT 0
`define SCSS_PLL_POWER_ON_BIT 6
`define SCSS_CLKSRC_RST 8'h00
`define SCSS_PLL_CONTROL_RST 8'hC1
`define SCSS_PLL_CONTROL_WMASK 8'hFF
`define SCSS_ZERO8 8'h00
`define SCSS_STRAP_WAIT 2'h2
`define SCSS_BUS_DIV 2
`endif

/* logic/scss_strap.sv */
// capture of the oscillator configuration strap after reset release
`timescale 1ns/100ps
`include "scss_regs.svh"
module scss_strap (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic strap_in,
    output logic strap_q
);
    logic done_r;
    logic val_r;
    logic [1:0] cnt_r;
    logic done_nxt;
    logic val_nxt;
    logic [1:0] cnt_nxt;
    // wait until the synchroniser holds the real strap level
    always_comb begin
        done_nxt = done_r;
        val_nxt = val_r;
        cnt_nxt = cnt_r;
        if (!done_r) begin
            if (cnt_r == `SCSS_STRAP_WAIT) begin
                val_nxt = strap_in;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
            val_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            done_r <= done_nxt;
            val_r <= val_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign strap_q = val_r;
endmodule

/* logic/scss_sync2.sv */
// two-flop synchroniser for a level
`timescale 1ns/100ps
module scss_sync2 (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    logic sync_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end
    assign dout = sync_r;
endmodule

/* logic/scss_top.sv */
// clock source select and low-power control top
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "scss_regs.svh"
module scss_top
    import scss_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input scss_pkg::scss_bus_req_t bus_req,
    output logic [7:0] rdata,
    input scss_pkg::scss_mode_t mode,
    input wire logic pll_lock,
    input wire logic osc_cfg_in,
    output scss_pkg::scss_ctl_t ctl
);
    import scss_pkg::*;

    logic lock_s;
    logic cfg_s;
    logic cfg_q;

    // lock is asynchronous to the bus clock
    scss_sync2 u_lock_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din(pll_lock),
        .dout(lock_s)
    );
    scss_sync2 u_cfg_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din(osc_cfg_in),
        .dout(cfg_s)
    );
    scss_strap u_strap (
        .mclk(mclk),
        .rstn(rstn),
        .strap_in(cfg_s),
        .strap_q(cfg_q)
    );

    function automatic logic hit(input logic [`SCSS_ADDR_W-1:0] a,
                                 input logic [`SCSS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic wr_clk;
    logic wr_pll;
    assign wr_clk = bus_req.wr && hit(bus_req.addr, `SCSS_OFF_CLKSRC);
    assign wr_pll = bus_req.wr && hit(bus_req.addr, `SCSS_OFF_PLL_CONTROL);

    // register state
    logic sel_r, sel_nxt;
    logic stoprun_r, stoprun_nxt;
    logic pll_halt_in_wait_r, pll_halt_in_wait_nxt;
    logic periodic_timer_halt_in_wait_r, periodic_timer_halt_in_wait_nxt;
    logic watchdog_halt_in_wait_r, watchdog_halt_in_wait_nxt;
    logic copwr_r, copwr_nxt;
    logic [7:0] pll_control_r, pll_control_nxt;
    scss_lp_t lp_r, lp_nxt;

    always_comb begin
        lp_nxt = SCSS_RUN;
        if (mode.stop_req) begin
            lp_nxt = SCSS_STOP;
        end else if (mode.wait_req) begin
            lp_nxt = SCSS_WAIT;
        end
    end

    always_comb begin
        sel_nxt = sel_r;
        stoprun_nxt = stoprun_r;
        pll_halt_in_wait_nxt = pll_halt_in_wait_r;
        periodic_timer_halt_in_wait_nxt = periodic_timer_halt_in_wait_r;
        watchdog_halt_in_wait_nxt = watchdog_halt_in_wait_r;
        copwr_nxt = copwr_r;
        pll_control_nxt = pll_control_r;
        if (wr_clk) begin
            // a one is only accepted with a stable lock
            sel_nxt = bus_req.wdata[`SCSS_SEL_BIT] & lock_s;
            stoprun_nxt = bus_req.wdata[`SCSS_STOPRUN_BIT];
            pll_halt_in_wait_nxt = bus_req.wdata[`SCSS_PLL_HALT_IN_WAIT_BIT];
            periodic_timer_halt_in_wait_nxt = bus_req.wdata[`SCSS_PERIODIC_TIMER_HALT_IN_WAIT_BIT];
            if (mode.special_mode || !copwr_r) begin
                watchdog_halt_in_wait_nxt = bus_req.wdata[`SCSS_WATCHDOG_HALT_IN_WAIT_BIT];
                copwr_nxt = 1'b1;
            end
        end
        if (wr_pll) begin
            pll_control_nxt = bus_req.wdata & `SCSS_PLL_CONTROL_WMASK;
        end
        // stop, self clock or wait with pll_halt_in_wait_r override any write; no automatic restore
        if (mode.self_clock || mode.stop_req ||
            (mode.wait_req && pll_halt_in_wait_r)) begin
            sel_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sel_r <= 1'b0;
            stoprun_r <= 1'b0;
            pll_halt_in_wait_r <= 1'b0;
            periodic_timer_halt_in_wait_r <= 1'b0;
            watchdog_halt_in_wait_r <= 1'b0;
            copwr_r <= 1'b0;
            pll_control_r <= `SCSS_PLL_CONTROL_RST;
            lp_r <= SCSS_RUN;
        end else begin
            sel_r <= sel_nxt;
            stoprun_r <= stoprun_nxt;
            pll_halt_in_wait_r <= pll_halt_in_wait_nxt;
            periodic_timer_halt_in_wait_r <= periodic_timer_halt_in_wait_nxt;
            watchdog_halt_in_wait_r <= watchdog_halt_in_wait_nxt;
            copwr_r <= copwr_nxt;
            pll_control_r <= pll_control_nxt;
            lp_r <= lp_nxt;
        end
    end

    // read path and controls
    logic [7:0] rdata_nxt;
    scss_ctl_t ctl_nxt;
    logic [7:0] clk_view;

    always_comb begin
        clk_view = `SCSS_ZERO8;
        clk_view[`SCSS_SEL_BIT] = sel_r;
        clk_view[`SCSS_STOPRUN_BIT] = stoprun_r;
        clk_view[`SCSS_CFG_BIT] = cfg_q;
        clk_view[`SCSS_PLL_HALT_IN_WAIT_BIT] = pll_halt_in_wait_r;
        clk_view[`SCSS_PERIODIC_TIMER_HALT_IN_WAIT_BIT] = periodic_timer_halt_in_wait_r;
        clk_view[`SCSS_WATCHDOG_HALT_IN_WAIT_BIT] = watchdog_halt_in_wait_r;
        rdata_nxt = `SCSS_ZERO8;
        if (bus_req.rd) begin
            if (hit(bus_req.addr, `SCSS_OFF_CLKSRC)) begin
                rdata_nxt = clk_view;
            end else if (hit(bus_req.addr, `SCSS_OFF_PLL_CONTROL)) begin
                rdata_nxt = pll_control_r;
            end
        end
    end

    always_comb begin
        ctl_nxt.use_pll = sel_nxt;
        ctl_nxt.osc_enable = !(lp_nxt == SCSS_STOP) || stoprun_nxt;
        ctl_nxt.pll_power = mode.self_clock ||
            (pll_control_nxt[`SCSS_PLL_POWER_ON_BIT] && !(lp_nxt == SCSS_WAIT && pll_halt_in_wait_nxt));
        ctl_nxt.rti_run = !(lp_nxt == SCSS_WAIT && periodic_timer_halt_in_wait_nxt);
        ctl_nxt.rti_init = (lp_nxt == SCSS_WAIT) && periodic_timer_halt_in_wait_nxt;
        ctl_nxt.cop_run = !(lp_nxt == SCSS_WAIT && watchdog_halt_in_wait_nxt);
        ctl_nxt.cop_init = (lp_nxt == SCSS_WAIT) && watchdog_halt_in_wait_nxt;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= `SCSS_ZERO8;
            ctl <= '{use_pll: 1'b0, osc_enable: 1'b1, pll_power: 1'b1,
                     rti_run: 1'b1, rti_init: 1'b0, cop_run: 1'b1, cop_init: 1'b0};
        end else begin
            rdata <= rdata_nxt;
            ctl <= ctl_nxt;
        end
    end


    chk_sel_needs_lock: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_clk && !lock_s && !sel_r) |=> !sel_r)
        else $error("pll select set without lock");

    chk_sel_lowpwr_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (mode.stop_req || mode.self_clock) |=> !sel_r && !ctl.use_pll)
        else $error("pll select not cleared");

    chk_src_follows_sel: assert property (@(posedge mclk) disable iff (!rstn)
        ctl.use_pll == sel_r)
        else $error("source differs from select");

    chk_osc_stop_off: assert property (@(posedge mclk) disable iff (!rstn)
        (mode.stop_req && !$past(stoprun_r, 1) && !wr_clk && !$past(wr_clk, 1))
        |=> !ctl.osc_enable)
        else $error("oscillator running in stop");

    chk_cfg_held: assert property (@(posedge mclk) disable iff (!rstn)
        $past(u_strap.done_r, 1) |-> $stable(cfg_q))
        else $error("config status changed");

    chk_pll_wait_down: assert property (@(posedge mclk) disable iff (!rstn)
        (mode.wait_req && !mode.stop_req && !mode.self_clock && pll_halt_in_wait_r && !wr_clk)
        |=> !ctl.pll_power && !ctl.use_pll)
        else $error("pll not down in wait");

    chk_cop_once: assert property (@(posedge mclk) disable iff (!rstn)
        (copwr_r && !mode.special_mode) |=> $stable(watchdog_halt_in_wait_r))
        else $error("watchdog field rewritten");

    chk_selfclk_pll_on: assert property (@(posedge mclk) disable iff (!rstn)
        mode.self_clock |=> ctl.pll_power)
        else $error("pll off in self clock");

    chk_timer_wait_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_WAIT && periodic_timer_halt_in_wait_r) |-> !ctl.rti_run && ctl.rti_init)
        else $error("timer running in wait");

    chk_timer_wait_run: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_WAIT && !periodic_timer_halt_in_wait_r) |-> ctl.rti_run && !ctl.rti_init)
        else $error("timer halted in wait");

    chk_timer_awake: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r != SCSS_WAIT) |-> ctl.rti_run && !ctl.rti_init)
        else $error("timer halted outside wait");

    chk_cop_wait_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_WAIT && watchdog_halt_in_wait_r) |-> !ctl.cop_run && ctl.cop_init)
        else $error("watchdog running in wait");

    chk_cop_wait_run: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_WAIT && !watchdog_halt_in_wait_r) |-> ctl.cop_run && !ctl.cop_init)
        else $error("watchdog halted in wait");

    chk_cop_awake: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r != SCSS_WAIT) |-> ctl.cop_run && !ctl.cop_init)
        else $error("watchdog halted outside wait");

    chk_osc_pseudo_stop: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_STOP && stoprun_r) |-> ctl.osc_enable)
        else $error("oscillator off in pseudo stop");

    chk_osc_full_stop: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_STOP && !stoprun_r) |-> !ctl.osc_enable)
        else $error("oscillator on in full stop");

    chk_osc_awake: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r != SCSS_STOP) |-> ctl.osc_enable)
        else $error("oscillator off outside stop");

    chk_cfg_readback: assert property (@(posedge mclk) disable iff (!rstn)
        (bus_req.rd && hit(bus_req.addr, `SCSS_OFF_CLKSRC)) |=> rdata[`SCSS_CFG_BIT] == cfg_q)
        else $error("config status read wrong");

    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !bus_req.rd |=> rdata == `SCSS_ZERO8)
        else $error("read data without read");

    chk_rdata_clksrc: assert property (@(posedge mclk) disable iff (!rstn)
        (bus_req.rd && hit(bus_req.addr, `SCSS_OFF_CLKSRC)) |=> rdata == $past(clk_view))
        else $error("select register read wrong");

    chk_rdata_pll_control: assert property (@(posedge mclk) disable iff (!rstn)
        (bus_req.rd && hit(bus_req.addr, `SCSS_OFF_PLL_CONTROL)) |=> rdata == $past(pll_control_r))
        else $error("pll control read wrong");

    chk_sel_no_restore: assert property (@(posedge mclk) disable iff (!rstn)
        (!sel_r && !wr_clk) |=> !sel_r)
        else $error("pll select restored by itself");

    chk_pll_power_on_held: assert property (@(posedge mclk) disable iff (!rstn)
        !wr_pll |=> $stable(pll_control_r))
        else $error("pll control changed without write");

    chk_pll_awake: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r != SCSS_WAIT && pll_control_r[`SCSS_PLL_POWER_ON_BIT]) |-> ctl.pll_power)
        else $error("pll off outside wait");

    chk_pll_power_on_off: assert property (@(posedge mclk) disable iff (!rstn)
        (!$past(mode.self_clock) && !pll_control_r[`SCSS_PLL_POWER_ON_BIT]) |-> !ctl.pll_power)
        else $error("pll on while switched off");

    chk_sel_wait_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (mode.wait_req && pll_halt_in_wait_r) |=> !sel_r)
        else $error("pll select kept in wait");

    chk_sel_locked_set: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_clk && bus_req.wdata[`SCSS_SEL_BIT] && lock_s && !mode.self_clock &&
            !mode.stop_req && !(mode.wait_req && pll_halt_in_wait_r)) |=> sel_r)
        else $error("pll select refused with lock");

    chk_lp_stop_wins: assert property (@(posedge mclk) disable iff (!rstn)
        (mode.stop_req && mode.wait_req) |=> lp_r == SCSS_STOP && ctl.rti_run)
        else $error("wait taken over stop");

    chk_use_pll_run: assert property (@(posedge mclk) disable iff (!rstn)
        (lp_r == SCSS_RUN && sel_r) |-> ctl.use_pll)
        else $error("oscillator source with select set");

    chk_copwr_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        copwr_r |=> copwr_r)
        else $error("watchdog write flag lost");

    chk_cop_first_write: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_clk && !copwr_r) |=> copwr_r && watchdog_halt_in_wait_r == $past(bus_req.wdata[`SCSS_WATCHDOG_HALT_IN_WAIT_BIT]))
        else $error("first watchdog write lost");
endmodule

/* sim/scss_top_test.sv */
// self-checking testbench for the clock source select block
`timescale 1ns/100ps
`include "scss_regs.svh"
module scss_top_test;
    import scss_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    scss_bus_req_t bus_req = '0;
    scss_mode_t mode = '0;
    logic pll_lock = 1'b0;
    logic osc_cfg_in = 1'b1;
    logic [7:0] rdata;
    scss_ctl_t ctl;
    int failures = 0;
    int checks = 0;

    initial forever #25 mclk = ~mclk;

    scss_top dut (
        .mclk(mclk),
        .rstn(rstn),
        .bus_req(bus_req),
        .rdata(rdata),
        .mode(mode),
        .pll_lock(pll_lock),
        .osc_cfg_in(osc_cfg_in),
        .ctl(ctl)
    );

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ctl packed as use_pll, osc_enable, pll_power, rti_run, rti_init, cop_run, cop_init
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        cyc(2);
        chk("ctl reset", {1'b0, ctl}, 8'h3A);
        rd_chk("clksrc reset", `SCSS_OFF_CLKSRC, 8'h20);
        rd_chk("pll_control reset", `SCSS_OFF_PLL_CONTROL, `SCSS_PLL_CONTROL_RST);
        rd_chk("unmapped", 4'h0, 8'h00);
        $display("test reset done");

        wr_reg(`SCSS_OFF_CLKSRC, 8'h03);
        @(posedge mclk) mode.wait_req <= 1'b1;
        cyc(2);
        chk("ctl wait halts", {1'b0, ctl}, 8'h35);
        @(posedge mclk) mode.wait_req <= 1'b0;
        cyc(2);
        chk("ctl wait exit", {1'b0, ctl}, 8'h3A);
        wr_reg(`SCSS_OFF_CLKSRC, 8'h02);
        rd_chk("watchdog once", `SCSS_OFF_CLKSRC, 8'h23);
        @(posedge mclk) mode.special_mode <= 1'b1;
        wr_reg(`SCSS_OFF_CLKSRC, 8'h00);
        rd_chk("watchdog special", `SCSS_OFF_CLKSRC, 8'h20);
        $display("test wait halts done");

        wr_reg(`SCSS_OFF_CLKSRC, 8'h80);
        cyc(1);
        chk("ctl unlocked", {1'b0, ctl}, 8'h3A);
        rd_chk("sel unlocked", `SCSS_OFF_CLKSRC, 8'h20);
        @(posedge mclk) pll_lock <= 1'b1;
        cyc(4);
        wr_reg(`SCSS_OFF_CLKSRC, 8'h80);
        cyc(1);
        chk("ctl locked", {1'b0, ctl}, 8'h7A);
        rd_chk("sel locked", `SCSS_OFF_CLKSRC, 8'hA0);
        $display("test lock done");

        wr_reg(`SCSS_OFF_CLKSRC, 8'h88);
        @(posedge mclk) mode.wait_req <= 1'b1;
        cyc(2);
        chk("ctl pll wait", {1'b0, ctl}, 8'h2A);
        rd_chk("sel pll wait", `SCSS_OFF_CLKSRC, 8'h28);
        rd_chk("pll_power_on in wait", `SCSS_OFF_PLL_CONTROL, 8'hC1);
        @(posedge mclk) mode.wait_req <= 1'b0;
        cyc(2);
        chk("ctl after wait", {1'b0, ctl}, 8'h3A);
        rd_chk("sel after wait", `SCSS_OFF_CLKSRC, 8'h28);
        $display("test pll wait done");

        wr_reg(`SCSS_OFF_CLKSRC, 8'h80);
        @(posedge mclk) mode.stop_req <= 1'b1;
        cyc(2);
        chk("stop osc off", {6'b0, ctl.use_pll, ctl.osc_enable}, 8'h00);
        @(posedge mclk) mode.stop_req <= 1'b0;
        wr_reg(`SCSS_OFF_CLKSRC, 8'h40);
        @(posedge mclk) mode.stop_req <= 1'b1;
        cyc(2);
        chk("stop osc run", {6'b0, ctl.use_pll, ctl.osc_enable}, 8'h01);
        @(posedge mclk) mode.stop_req <= 1'b0;
        $display("test stop done");

        wr_reg(`SCSS_OFF_PLL_CONTROL, 8'h81);
        cyc(1);
        chk("pll off", {7'b0, ctl.pll_power}, 8'h00);
        wr_reg(`SCSS_OFF_CLKSRC, 8'h80);
        @(posedge mclk) mode.self_clock <= 1'b1;
        cyc(2);
        chk("self clock", {6'b0, ctl.use_pll, ctl.pll_power}, 8'h01);
        rd_chk("pll_power_on readback", `SCSS_OFF_PLL_CONTROL, 8'h81);
        wr_reg(4'h0, 8'hFF);
        rd_chk("unmapped write", 4'h0, 8'h00);
        $display("test self clock done");
        end_sim();
    end
endmodule
